// file: rtl/bil_pkg.sv
/*
 Package for the boot image loader: timing, image constants, states and carriers.
 Assumes a 200 MHz system clock.
*/
package bil_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int RST_DLY_NS = 15000;
	localparam int RST_DLY_CYC = (RST_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_W = 12;
	// ----------------------------------------
	// Image and CRC constants
	// ----------------------------------------
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_PRESET = 32'hFFFFFFFF;
	localparam logic [31:0] SKIP_MARK = 32'h0D15AB1E;
	localparam int SEC_BOOT_BIT = 5;
	// ----------------------------------------
	// Memory geometry
	// ----------------------------------------
	localparam int OTP_AW = 11;
	localparam logic [OTP_AW-1:0] OTP_SEC_ADDR = 11'h7FF;
	localparam logic [OTP_AW-1:0] OTP_BOOT_ADDR = 11'h000;
	localparam int RAM_AW = 18;
	localparam logic [RAM_AW-1:0] RAM_BASE = 18'h00000;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_HOLD, ST_INTRST, ST_SEC_REQ, ST_SEC_WAIT, ST_SRC_SEL,
		ST_LEN, ST_PROG, ST_TRAIL, ST_CHECK, ST_RUN, ST_ERROR
	} bil_state_e;
	typedef struct packed {
		logic sclk;
		logic [3:0] dat;
	} bil_qspi_in_s;
	typedef struct packed {
		logic we;
		logic [RAM_AW-1:0] addr;
		logic [7:0] data;
	} bil_ram_wr_s;
endpackage : bil_pkg

// file: rtl/bil_crc.sv
/*
 Byte-wise reflected CRC-32 engine, one byte per enabled cycle.
 Assumes bytes arrive from logic on the same clock.
*/
`timescale 1ns/10ps
module bil_crc (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkEn,
	// Control and data
	input wire logic init,
	input wire logic byteVld,
	input wire logic [7:0] byteVal,
	// Result
	output logic [31:0] crc_q
);
	// ----------------------------------------
	// Byte update, LSB first
	// ----------------------------------------
	function automatic logic [31:0] bil_crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {24'h000000, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ bil_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : bil_crc_byte

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			crc_q <= bil_pkg::CRC_PRESET;
		end else if (clkEn) begin
			if (init) begin
				crc_q <= bil_pkg::CRC_PRESET;
			end else if (byteVld) begin
				crc_q <= bil_crc_byte(crc_q, byteVal);
			end
		end
	end

	AST_CRC_PRESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && init) |=> (crc_q == bil_pkg::CRC_PRESET))
		else $error("CRC not preset to all ones");
	AST_CRC_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && !init && byteVld) |=> (crc_q == bil_crc_byte($past(crc_q), $past(byteVal))))
		else $error("CRC byte update wrong");
endmodule : bil_crc

// file: rtl/boot_image_loader.sv
/*
 Boot sequencer and boot image loader for one tile.
 Assumes OTP answers a read one cycle after otpRdEn, and the flash streams nibbles on its own clock.
*/
`timescale 1ns/10ps
module boot_image_loader (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkEn,
	// Chip reset pin
	input wire logic chipRst_n,
	// Tile control
	output logic tileRst_n,
	output logic pullDownEn,
	output logic runStart,
	output logic [bil_pkg::RAM_AW-1:0] runAddr,
	output logic bootErr,
	// OTP read port
	output logic otpRdEn,
	output logic [bil_pkg::OTP_AW-1:0] otpAddr,
	input wire logic [31:0] otpData,
	// Quad-SPI flash
	output logic flashCs_n,
	input wire bil_pkg::bil_qspi_in_s qspiIn,
	// RAM write port
	output bil_pkg::bil_ram_wr_s ramWr
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic rstS1_q, rstS2_q;
	bil_pkg::bil_qspi_in_s qS1_q, qS2_q;
	logic sclkPrev_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rstS1_q <= 1'b0;
			rstS2_q <= 1'b0;
			qS1_q <= '0;
			qS2_q <= '0;
			sclkPrev_q <= 1'b0;
		end else if (clkEn) begin
			rstS1_q <= chipRst_n;
			rstS2_q <= rstS1_q;
			qS1_q <= qspiIn;
			qS2_q <= qS1_q;
			sclkPrev_q <= qS2_q.sclk;
		end
	end
	logic sclkRise;
	assign sclkRise = qS2_q.sclk && !sclkPrev_q;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	bil_pkg::bil_state_e state_q;
	logic [bil_pkg::DLY_W-1:0] dly_q;
	logic secBoot_q;
	logic [31:0] word_q;
	logic [1:0] bIdx_q;
	logic [31:0] wordsLeft_q;
	logic [31:0] crc;
	logic byteVld;
	logic [7:0] byteVal;
	logic inStream;
	logic [31:0] fullWord;
	logic needCrc;
	logic crcOk;
	assign inStream = (state_q == bil_pkg::ST_LEN) || (state_q == bil_pkg::ST_PROG) || (state_q == bil_pkg::ST_TRAIL);
	assign fullWord = {byteVal, word_q[31:8]};
	assign needCrc = (word_q != bil_pkg::SKIP_MARK);
	assign crcOk = ((~crc) == word_q);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= bil_pkg::ST_HOLD;
		end else if (clkEn) begin
			if (!rstS2_q) begin
				state_q <= bil_pkg::ST_HOLD;
			end else begin
				case (state_q)
					bil_pkg::ST_HOLD: state_q <= bil_pkg::ST_INTRST;
					bil_pkg::ST_INTRST: begin
						if (dly_q == bil_pkg::DLY_W'(bil_pkg::RST_DLY_CYC - 1)) begin
							state_q <= bil_pkg::ST_SEC_REQ;
						end
					end
					bil_pkg::ST_SEC_REQ: state_q <= bil_pkg::ST_SEC_WAIT;
					bil_pkg::ST_SEC_WAIT: state_q <= bil_pkg::ST_SRC_SEL;
					bil_pkg::ST_SRC_SEL: state_q <= bil_pkg::ST_LEN;
					bil_pkg::ST_LEN: begin
						if (byteVld && bIdx_q == 2'h3) begin
							state_q <= (fullWord == 32'h00000000) ? bil_pkg::ST_TRAIL : bil_pkg::ST_PROG;
						end
					end
					bil_pkg::ST_PROG: begin
						if (byteVld && bIdx_q == 2'h3 && wordsLeft_q == 32'h00000001) begin
							state_q <= bil_pkg::ST_TRAIL;
						end
					end
					bil_pkg::ST_TRAIL: begin
						if (byteVld && bIdx_q == 2'h3) begin
							state_q <= bil_pkg::ST_CHECK;
						end
					end
					bil_pkg::ST_CHECK: state_q <= (needCrc && !crcOk) ? bil_pkg::ST_ERROR : bil_pkg::ST_RUN;
					bil_pkg::ST_RUN: state_q <= bil_pkg::ST_RUN;
					bil_pkg::ST_ERROR: state_q <= bil_pkg::ST_ERROR;
					default: state_q <= bil_pkg::ST_HOLD;
				endcase
			end
		end
	end

	// Internal reset delay counter
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dly_q <= '0;
		end else if (clkEn) begin
			dly_q <= (state_q == bil_pkg::ST_INTRST) ? dly_q + 1'b1 : '0;
		end
	end

	// Security word capture
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			secBoot_q <= 1'b0;
		end else if (clkEn && state_q == bil_pkg::ST_SEC_WAIT) begin
			secBoot_q <= otpData[bil_pkg::SEC_BOOT_BIT];
		end
	end

	// Word assembly and program length
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			word_q <= '0;
			bIdx_q <= '0;
			wordsLeft_q <= '0;
		end else if (clkEn) begin
			if (state_q == bil_pkg::ST_SRC_SEL) begin
				bIdx_q <= '0;
			end else if (inStream && byteVld) begin
				word_q <= fullWord;
				bIdx_q <= bIdx_q + 2'h1;
				if (state_q == bil_pkg::ST_LEN && bIdx_q == 2'h3) begin
					wordsLeft_q <= fullWord;
				end else if (state_q == bil_pkg::ST_PROG && bIdx_q == 2'h3) begin
					wordsLeft_q <= wordsLeft_q - 32'h00000001;
				end
			end
		end
	end

	// ----------------------------------------
	// Byte sources
	// ----------------------------------------
	logic otpHave_q, otpPend_q;
	logic [31:0] otpWord_q;
	logic [1:0] otpIdx_q;
	logic [3:0] nibHi_q;
	logic nibHalf_q;
	logic [7:0] flashByte_q;
	logic flashVld_q;
	assign otpRdEn = clkEn && ((state_q == bil_pkg::ST_SEC_REQ)
		|| (inStream && secBoot_q && !otpHave_q && !otpPend_q));
	assign byteVld = inStream && (secBoot_q ? otpHave_q : flashVld_q);
	assign byteVal = secBoot_q ? otpWord_q[{otpIdx_q, 3'h0} +: 8] : flashByte_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			otpAddr <= bil_pkg::OTP_SEC_ADDR;
			otpHave_q <= 1'b0;
			otpPend_q <= 1'b0;
			otpWord_q <= '0;
			otpIdx_q <= '0;
		end else if (clkEn) begin
			if (state_q == bil_pkg::ST_HOLD) begin
				otpAddr <= bil_pkg::OTP_SEC_ADDR;
				otpHave_q <= 1'b0;
				otpPend_q <= 1'b0;
			end else if (state_q == bil_pkg::ST_SRC_SEL) begin
				otpAddr <= bil_pkg::OTP_BOOT_ADDR;
			end else if (inStream && secBoot_q) begin
				otpPend_q <= otpRdEn;
				if (otpPend_q) begin
					otpWord_q <= otpData;
					otpHave_q <= 1'b1;
					otpIdx_q <= '0;
				end else if (otpHave_q) begin
					otpIdx_q <= otpIdx_q + 2'h1;
					if (otpIdx_q == 2'h3) begin
						otpHave_q <= 1'b0;
						otpAddr <= otpAddr + 1'b1;
					end
				end
			end
		end
	end

	// Flash nibble assembly, high nibble first
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			nibHi_q <= '0;
			nibHalf_q <= 1'b0;
			flashByte_q <= '0;
			flashVld_q <= 1'b0;
		end else if (clkEn) begin
			flashVld_q <= 1'b0;
			if (!inStream || secBoot_q) begin
				nibHalf_q <= 1'b0;
			end else if (sclkRise) begin
				nibHalf_q <= !nibHalf_q;
				if (!nibHalf_q) begin
					nibHi_q <= qS2_q.dat;
				end else begin
					flashByte_q <= {nibHi_q, qS2_q.dat};
					flashVld_q <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// CRC
	// ----------------------------------------
	logic crcStep;
	assign crcStep = byteVld && (state_q == bil_pkg::ST_LEN || state_q == bil_pkg::ST_PROG);
	bil_crc u_crc (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.init(state_q == bil_pkg::ST_SRC_SEL),
		.byteVld(crcStep),
		.byteVal(byteVal),
		.crc_q(crc)
	);

	// ----------------------------------------
	// RAM write and outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ramWr <= '0;
		end else if (clkEn) begin
			ramWr.we <= (state_q == bil_pkg::ST_PROG) && byteVld;
			ramWr.data <= byteVal;
			if (state_q == bil_pkg::ST_LEN) begin
				ramWr.addr <= bil_pkg::RAM_BASE;
			end else if (ramWr.we) begin
				ramWr.addr <= ramWr.addr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tileRst_n <= 1'b0;
			pullDownEn <= 1'b1;
			runStart <= 1'b0;
			bootErr <= 1'b0;
		end else if (clkEn) begin
			tileRst_n <= (state_q == bil_pkg::ST_RUN) && rstS2_q;
			pullDownEn <= !rstS2_q || (state_q == bil_pkg::ST_HOLD);
			runStart <= (state_q == bil_pkg::ST_CHECK) && !(needCrc && !crcOk) && rstS2_q;
			bootErr <= (state_q == bil_pkg::ST_ERROR) || ((state_q == bil_pkg::ST_CHECK) && needCrc && !crcOk);
		end
	end
	assign runAddr = bil_pkg::RAM_BASE;
	assign flashCs_n = !(inStream && !secBoot_q);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_HOLD_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && !rstS2_q) |=> (!tileRst_n && state_q == bil_pkg::ST_HOLD))
		else $error("Tile left reset while pin low");
	AST_PULLDOWN: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && !rstS2_q) |=> pullDownEn)
		else $error("Pull-downs off during reset");
	AST_BOOT_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && state_q == bil_pkg::ST_SEC_REQ) |-> ($past(dly_q) == bil_pkg::DLY_W'(bil_pkg::RST_DLY_CYC - 1)))
		else $error("Boot started before internal reset delay");
	AST_SEC_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == bil_pkg::ST_SEC_REQ) |-> (otpAddr == bil_pkg::OTP_SEC_ADDR))
		else $error("Security word not read first");
	AST_OTP_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && rstS2_q && state_q == bil_pkg::ST_SRC_SEL) |=> (otpAddr == bil_pkg::OTP_BOOT_ADDR))
		else $error("OTP boot not from address zero");
	AST_FLASH_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(inStream && !secBoot_q) |-> (!flashCs_n && !otpRdEn))
		else $error("Wrong boot source");
	AST_RAM_BASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && state_q == bil_pkg::ST_LEN) |=> (ramWr.addr == bil_pkg::RAM_BASE))
		else $error("Program not at RAM base");
	AST_CRC_FAIL: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && rstS2_q && state_q == bil_pkg::ST_CHECK && needCrc && !crcOk) |=> (bootErr && !runStart) ##1 !tileRst_n)
		else $error("Bad CRC did not block start");
	AST_SKIP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && rstS2_q && state_q == bil_pkg::ST_CHECK && word_q == bil_pkg::SKIP_MARK) |=> runStart)
		else $error("Skip marker did not start program");
endmodule : boot_image_loader

// file: tb/bil_flash_model.sv
/*
 Behavioural embedded quad-SPI flash that streams a boot image, high nibble first.
 Assumes the bench fills img before the loader selects the flash.
*/
`timescale 1ns/10ps
module bil_flash_model (
	// Select from loader
	input wire logic flashCs_n,
	// Clock and nibbles to loader
	output bil_pkg::bil_qspi_in_s qspiIn
);
	logic [7:0] img[$];
	logic [7:0] b;
	// ----------------------------------------
	// Stream, clock still outside frames
	// ----------------------------------------
	initial begin
		qspiIn = '0;
		forever begin
			wait (flashCs_n === 1'b0);
			while (flashCs_n === 1'b0 && img.size() > 0) begin
				b = img.pop_front();
				for (int i = 1; i >= 0; i--) begin
					qspiIn.dat = b[i*4+:4];
					#24 qspiIn.sclk = 1'b1;
					#24 qspiIn.sclk = 1'b0;
				end
			end
			qspiIn.dat = ~qspiIn.dat;
			wait (flashCs_n === 1'b1);
		end
	end
endmodule : bil_flash_model

// file: tb/testbench.sv
/*
 Self-checking bench: flash and OTP boots with good, skipped and bad CRC.
 Assumes OTP answers one cycle after otpRdEn; flash model streams at 48 ns.
*/
`timescale 1ns/10ps
module testbench;
	logic clk_sys, rst_n, clkEn, chipRst_n;
	logic tileRst_n, pullDownEn, runStart, bootErr, otpRdEn, flashCs_n, csSeen;
	logic [17:0] runAddr;
	logic [10:0] otpAddr;
	logic [31:0] otpData;
	bil_pkg::bil_qspi_in_s qspiIn;
	bil_pkg::bil_ram_wr_s ramWr;
	logic [31:0] otpMem[0:2047];
	logic [7:0] expQ[$];
	int error_cnt, tests_run, cyc, ramIdx;

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	boot_image_loader boot_image_loader_inst (.clk_sys, .rst_n, .clkEn, .chipRst_n, .tileRst_n, .pullDownEn,
		.runStart, .runAddr, .bootErr, .otpRdEn, .otpAddr, .otpData, .flashCs_n, .qspiIn, .ramWr);
	bil_flash_model bil_flash_model_inst (.flashCs_n, .qspiIn);

	// ----------------------------------------
	// OTP model and monitors
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (otpRdEn === 1'b1) otpData <= otpMem[otpAddr];
		else otpData <= ~otpData;
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			conclude();
		end
	end

	always @(negedge clk_sys) begin
		if (flashCs_n === 1'b0) csSeen = 1'b1;
		if (ramWr.we === 1'b1) begin
			check({14'h0, ramWr.addr, ramWr.data}, {14'h0, 18'(ramIdx), expQ[ramIdx]}, "ram write");
			ramIdx++;
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : check

	function automatic logic [31:0] crc32(input logic [7:0] q[$]);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		foreach (q[i]) begin
			c ^= {24'h0, q[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
		end
		return ~c;
	endfunction : crc32

	task automatic conclude();
		$display("Checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude

	// Mode 0 good CRC, 1 skip marker, 2 bad CRC
	task automatic boot(input bit fromOtp, input int len, input int mode);
		logic [7:0] img[$];
		logic [31:0] w;
		int n;
		w = len;
		img = {w[7:0], w[15:8], w[23:16], w[31:24]};
		expQ = {};
		for (int i = 0; i < len * 4; i++) expQ.push_back(8'($urandom));
		img = {img, expQ};
		w = (mode == 1) ? 32'h0D15AB1E : crc32(img) ^ 32'(mode == 2);
		img = {img, w[7:0], w[15:8], w[23:16], w[31:24]};
		for (int j = 0; j < img.size() / 4; j++) otpMem[j] = {img[4*j+3], img[4*j+2], img[4*j+1], img[4*j]};
		w = $urandom;
		w[5] = fromOtp;
		otpMem[2047] = w;
		bil_flash_model_inst.img.delete();
		if (!fromOtp) bil_flash_model_inst.img = img;
		ramIdx = 0;
		csSeen = 1'b0;
		@(posedge clk_sys);
		chipRst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		check({38'h0, tileRst_n, pullDownEn}, 40'h1, "held in reset");
		repeat (5) @(posedge clk_sys);
		chipRst_n <= 1'b1;
		n = 0;
		while (otpRdEn !== 1'b1 && n < 40000) begin
			@(negedge clk_sys);
			n++;
		end
		check(40'(n >= 3000 && n <= 30000), 40'h1, "boot delay");
		check({28'h0, flashCs_n, otpAddr}, {28'h0, 1'b1, 11'h7FF}, "security read first");
		n = 0;
		while (runStart !== 1'b1 && bootErr !== 1'b1 && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
		check({38'h0, runStart, bootErr}, {38'h0, mode != 2, mode == 2}, "start or error");
		check(40'(runAddr), 40'h0, "start address");
		@(negedge clk_sys);
		check({37'h0, tileRst_n, runStart, pullDownEn}, {37'h0, mode != 2, 2'h0}, "tile released");
		check(40'(ramIdx), 40'(len * 4), "byte count");
		check(40'(csSeen), 40'(!fromOtp), "boot source");
	endtask : boot

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(17976));
		rst_n = 1'b0;
		clkEn = 1'b1;
		chipRst_n = 1'b0;
		otpData = '0;
		csSeen = 1'b0;
		foreach (otpMem[i]) otpMem[i] = '0;
		repeat (8) @(posedge clk_sys);
		check({38'h0, tileRst_n, pullDownEn}, 40'h1, "reset state");
		rst_n <= 1'b1;
		boot(0, 3, 0);
		boot(0, 2, 1);
		boot(0, 2, 2);
		boot(1, 2, 0);
		boot(0, 0, 0);
		boot(1, 1, 2);
		for (int t = 0; t < 3; t++) boot($urandom_range(1), $urandom_range(4), $urandom_range(2));
		conclude();
	end
endmodule : testbench
